// ===== hw/reset_strap_and_board_test.sv
// reset strap capture, tri-state and in-circuit test control with AXI4-Lite status
// assumes pin inputs asynchronous to sys_clk; rst is the internal synchronous reset
`timescale 1ns/1ps
`default_nettype none
module reset_strap_and_board_test (
    input  wire logic                                 sys_clk,
    input  wire logic                                 rst,
    input  wire logic [11:0]                          awaddr,
    input  wire logic                                 awvalid,
    output logic                                      awready,
    input  wire logic [31:0]                          wdata,
    input  wire logic [3:0]                           wstrb,
    input  wire logic                                 wvalid,
    output logic                                      wready,
    output logic [1:0]                                bresp,
    output logic                                      bvalid,
    input  wire logic                                 bready,
    input  wire logic [11:0]                          araddr,
    input  wire logic                                 arvalid,
    output logic                                      arready,
    output logic [31:0]                               rdata,
    output logic [1:0]                                rresp,
    output logic                                      rvalid,
    input  wire logic                                 rready,
    input  wire logic                                 resetPinN,
    input  wire logic                                 crystalInput,
    input  wire logic                                 memoryDataZero,
    input  wire logic                                 memoryDataOne,
    input  wire logic [reset_strap_pkg::STRAP_W-1:0]  strapAddressLinesIn,
    output logic      [reset_strap_pkg::STRAP_W-1:0]  strapAddressLinesOut,
    output logic                                      strapAddressLinesOe,
    output logic                                      strapPullupEnable,
    input  wire logic [reset_strap_pkg::STRAP_W-1:0]  memoryAddress,
    input  wire logic [reset_strap_pkg::CHAIN_W-1:0]  chainPins,
    input  wire logic                                 verticalSyncIn,
    output logic                                      verticalSyncOut,
    output logic                                      verticalSyncOe,
    output logic                                      pinOutputEnable,
    input  wire logic                                 address24,
    input  wire logic                                 address25,
    input  wire logic                                 address26,
    input  wire logic                                 address27,
    input  wire logic                                 pixelClock,
    input  wire logic                                 memoryClock,
    output logic                                      address24Out,
    output logic                                      address25Out,
    output logic                                      activityIndicatorPin,
    output logic                                      backlightEnablePin,
    output logic [2:0]                                hostBusConfig,
    output logic                                      cpuClockDouble,
    output logic                                      externalOscSelect,
    output logic                                      upperAddressSelect,
    output logic                                      testModeEnable,
    output logic                                      clockTestMode,
    output logic                                      lowVoltageSelect
);
    logic [reset_strap_pkg::SYNC_W-1:0]  syncOut;
    logic                                pixSync;
    logic                                memClkSync;
    logic [reset_strap_pkg::CHAIN_W-1:0] chainSync;
    logic [reset_strap_pkg::STRAP_W-1:0] strapSync;
    logic                                md1Sync;
    logic                                md0Sync;
    logic                                xtalSync;
    logic                                resetNSync;
    logic                                xtalPrev;
    logic                                resetNPrev;
    logic                                xtalRise;
    logic                                resetLow;
    logic                                resetTrail;
    logic                                resetFall;
    logic                                chainAll;
    logic [reset_strap_pkg::STRAP_W-1:0] strap;
    logic [1:0]                          control;
    logic [31:0]                         readWord;
    logic                                readErr;
    logic                                writeGo;
    logic                                readGo;
    reset_strap_pkg::test_mode_t         mode;
    reset_strap_pkg::test_mode_t         next_mode;

    sync2 #(
        .W (reset_strap_pkg::SYNC_W)
    ) u_sync (
        .clk  (sys_clk),
        .din  ({pixelClock, memoryClock, chainPins, strapAddressLinesIn,
                memoryDataOne, memoryDataZero, crystalInput, resetPinN}),
        .dout (syncOut)
    );

    assign {pixSync, memClkSync, chainSync, strapSync,
            md1Sync, md0Sync, xtalSync, resetNSync} = syncOut;

    // crystal sits last so its own toggle closes the test
    // reset pin and analog outputs never join the chain
    and_chain #(
        .N (reset_strap_pkg::CHAIN_W + 1)
    ) u_chain (
        .chainIn ({xtalSync, chainSync}),
        .allHigh (chainAll)
    );

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            xtalPrev   <= 1'b0;
            resetNPrev <= 1'b1;
        end
        else
        begin
            xtalPrev   <= xtalSync;
            resetNPrev <= resetNSync;
        end
    end

    assign xtalRise   = xtalSync && !xtalPrev;
    assign resetLow   = !resetNSync;
    assign resetTrail = resetNSync && !resetNPrev;
    assign resetFall  = !resetNSync && resetNPrev;

    // tri-state entry outranks in-circuit entry when both data pins are low
    always_comb
    begin
        next_mode = mode;
        case (mode)
            reset_strap_pkg::MODE_NORMAL:
            begin
                if (xtalRise && resetLow && !md0Sync)
                    next_mode = reset_strap_pkg::MODE_TRISTATE;
                else if (xtalRise && resetLow && !md1Sync)
                    next_mode = reset_strap_pkg::MODE_ICT;
            end
            reset_strap_pkg::MODE_TRISTATE:
            begin
                // a crystal rise in the same cycle as a new pin reset keeps the mode (set wins)
                if (md0Sync || (resetFall && !xtalRise))
                    next_mode = reset_strap_pkg::MODE_NORMAL;
            end
            reset_strap_pkg::MODE_ICT:
            begin
                if (xtalRise && resetLow && !md0Sync)
                    next_mode = reset_strap_pkg::MODE_TRISTATE;
                else if (xtalRise && (md1Sync || !resetLow))
                    next_mode = reset_strap_pkg::MODE_NORMAL;
            end
            default:
                next_mode = reset_strap_pkg::MODE_NORMAL;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            mode <= reset_strap_pkg::MODE_NORMAL;
        else
            mode <= next_mode;
    end

    // straps captured once per pin reset, then frozen
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            strap <= reset_strap_pkg::STRAP_RESET;
        else if (resetTrail)
            strap <= strapSync;
    end

    // lines left undriven through pin reset so the pull-ups set the defaults
    assign strapPullupEnable   = resetLow;
    assign pinOutputEnable     = (mode == reset_strap_pkg::MODE_NORMAL);
    assign strapAddressLinesOe = pinOutputEnable && !resetLow;
    assign verticalSyncOe      = (mode != reset_strap_pkg::MODE_TRISTATE);

    assign hostBusConfig = {strap[reset_strap_pkg::DOUBLE_BIT], strap[reset_strap_pkg::ISA_BIT],
                            strap[reset_strap_pkg::LB_BIT]};
    assign cpuClockDouble     = !strap[reset_strap_pkg::DOUBLE_BIT];
    assign externalOscSelect  = !strap[reset_strap_pkg::OSC_BIT];
    assign upperAddressSelect = !strap[reset_strap_pkg::UPPER_BIT];
    assign testModeEnable     = !strap[reset_strap_pkg::TEST_BIT];
    assign clockTestMode      = !strap[reset_strap_pkg::TEST_BIT];
    assign lowVoltageSelect   = !strap[reset_strap_pkg::LV_BIT];

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            verticalSyncOut <= 1'b0;
        else if (mode == reset_strap_pkg::MODE_ICT)
            verticalSyncOut <= chainAll;
        else
            verticalSyncOut <= verticalSyncIn;
    end

    // clock test path is sampled, so it only shows clocks well below half of sys_clk
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            address24Out <= 1'b0;
            address25Out <= 1'b0;
        end
        else if (clockTestMode)
        begin
            address24Out <= pixSync;
            address25Out <= memClkSync;
        end
        else
        begin
            address24Out <= address24;
            address25Out <= address25;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            activityIndicatorPin <= 1'b0;
            backlightEnablePin   <= 1'b0;
        end
        else if (upperAddressSelect)
        begin
            activityIndicatorPin <= address26;
            backlightEnablePin   <= address27;
        end
        else
        begin
            activityIndicatorPin <= control[0];
            backlightEnablePin   <= control[1];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            strapAddressLinesOut <= '0;
        else
            strapAddressLinesOut <= memoryAddress;
    end

    // write side takes address and data in the same cycle, one response outstanding
    assign writeGo = awvalid && wvalid && !bvalid;
    assign awready = writeGo;
    assign wready  = writeGo;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bvalid <= 1'b0;
            bresp  <= reset_strap_pkg::RESP_OKAY;
        end
        else if (writeGo)
        begin
            bvalid <= 1'b1;
            if (awaddr == reset_strap_pkg::CTRL_OFF || awaddr == reset_strap_pkg::STATUS_OFF
                || awaddr == reset_strap_pkg::EXT1_OFF)
                bresp <= reset_strap_pkg::RESP_OKAY;
            else
                bresp <= reset_strap_pkg::RESP_SLVERR;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            control <= reset_strap_pkg::CTRL_RESET;
        else if (writeGo && awaddr == reset_strap_pkg::CTRL_OFF && wstrb[0])
            control <= wdata[1:0];
    end

    always_comb
    begin
        readWord = 32'h00000000;
        readErr  = 1'b0;
        if (araddr == reset_strap_pkg::STATUS_OFF)
        begin
            readWord[reset_strap_pkg::STRAP_W-1:0] = strap;
            readWord[reset_strap_pkg::STAT_TRI_BIT] = (mode == reset_strap_pkg::MODE_TRISTATE);
            readWord[reset_strap_pkg::STAT_ICT_BIT] = (mode == reset_strap_pkg::MODE_ICT);
        end
        else if (araddr == reset_strap_pkg::EXT1_OFF)
            readWord[reset_strap_pkg::EXT1_SPARE_BIT] = strap[reset_strap_pkg::SPARE_BIT];
        else if (araddr == reset_strap_pkg::CTRL_OFF)
            readWord[1:0] = control;
        else
            readErr = 1'b1;
    end

    assign arready = !rvalid;
    assign readGo  = arvalid && !rvalid;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= reset_strap_pkg::RESP_OKAY;
        end
        else if (readGo)
        begin
            rvalid <= 1'b1;
            rdata  <= readWord;
            rresp  <= readErr ? reset_strap_pkg::RESP_SLVERR : reset_strap_pkg::RESP_OKAY;
        end
        else if (rready)
            rvalid <= 1'b0;
    end

    a_tristate_entry: assert property (
        @(posedge sys_clk) disable iff (rst)
        xtalRise && resetLow && !md0Sync |=> mode == reset_strap_pkg::MODE_TRISTATE && !pinOutputEnable)
        else $error("tri-state not entered on crystal edge");

    a_tristate_exit: assert property (
        @(posedge sys_clk) disable iff (rst)
        mode == reset_strap_pkg::MODE_TRISTATE && md0Sync |=> mode == reset_strap_pkg::MODE_NORMAL)
        else $error("tri-state held with data bit zero high");

    a_tristate_reset: assert property (
        @(posedge sys_clk) disable iff (rst)
        mode == reset_strap_pkg::MODE_TRISTATE && resetFall && !xtalRise |=> mode == reset_strap_pkg::MODE_NORMAL)
        else $error("tri-state held after new pin reset");

    a_ict_entry: assert property (
        @(posedge sys_clk) disable iff (rst)
        mode == reset_strap_pkg::MODE_NORMAL && xtalRise && resetLow && md0Sync && !md1Sync
        |=> mode == reset_strap_pkg::MODE_ICT)
        else $error("in-circuit test not entered");

    a_ict_exit: assert property (
        @(posedge sys_clk) disable iff (rst)
        mode == reset_strap_pkg::MODE_ICT && xtalRise && md0Sync && md1Sync
        |=> mode == reset_strap_pkg::MODE_NORMAL)
        else $error("in-circuit test not left");

    a_vsync_and: assert property (
        @(posedge sys_clk) disable iff (rst)
        mode == reset_strap_pkg::MODE_ICT |=> verticalSyncOut == $past(chainAll))
        else $error("vertical sync does not follow chain");

    a_pins_hiz: assert property (
        @(posedge sys_clk) disable iff (rst)
        mode == reset_strap_pkg::MODE_ICT |-> !pinOutputEnable && !strapAddressLinesOe && verticalSyncOe)
        else $error("pin driven during in-circuit test");

    a_strap_latch: assert property (
        @(posedge sys_clk) disable iff (rst)
        resetTrail |=> strap == $past(strapSync) && cpuClockDouble == !$past(strapSync[2]))
        else $error("straps not captured at reset release");

    a_strap_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        !resetTrail |=> $stable(strap))
        else $error("straps changed outside reset release");

    a_pin_func: assert property (
        @(posedge sys_clk) disable iff (rst)
        upperAddressSelect |=> activityIndicatorPin == $past(address26) && backlightEnablePin == $past(address27))
        else $error("upper address pin function wrong");
endmodule
`default_nettype wire

// ===== hw/reset_strap_pkg.sv
// constants, strap field layout, register map and mode encoding for the reset strap block
// assumes one 40 MHz clock domain and an AXI4-Lite register port
package reset_strap_pkg;
    localparam int CHAIN_W = 32;
    localparam int STRAP_W = 9;
    localparam int SYNC_W  = CHAIN_W + STRAP_W + 6;

    localparam logic [STRAP_W-1:0] STRAP_RESET = 9'h1FF;
    localparam int LB_BIT     = 0;
    localparam int ISA_BIT    = 1;
    localparam int DOUBLE_BIT = 2;
    localparam int SPARE_BIT  = 3;
    localparam int OSC_BIT    = 5;
    localparam int UPPER_BIT  = 6;
    localparam int TEST_BIT   = 7;
    localparam int LV_BIT     = 8;

    localparam logic [11:0] STATUS_OFF = 12'h000;
    localparam logic [11:0] EXT1_OFF   = 12'h004;
    localparam logic [11:0] CTRL_OFF   = 12'h008;
    localparam int STAT_TRI_BIT = 16;
    localparam int STAT_ICT_BIT = 17;
    localparam int EXT1_SPARE_BIT = 3;
    localparam logic [1:0] CTRL_RESET  = 2'h0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_NORMAL   = 2'b00,
        MODE_TRISTATE = 2'b01,
        MODE_ICT      = 2'b11
    } test_mode_t;
endpackage

// ===== hw/sync2.sv
// two flip-flop synchroniser for pins that arrive from outside the clock domain
// assumes inputs quasi-static relative to the clock, word skew accepted
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        meta <= din;
        dout <= meta;
    end
endmodule
`default_nettype wire

// ===== hw/and_chain.sv
// wired-and observation path for in-circuit board test
// assumes inputs already synchronised; index 0 is the chain start
`timescale 1ns/1ps
`default_nettype none
module and_chain #(
    parameter int N = 2
) (
    input  wire logic [N-1:0] chainIn,
    output logic              allHigh
);
    logic [N:0] partial;

    assign partial[0] = 1'b1;
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1)
        begin : g_link
            // each stage passes the path on only while its pin is high
            assign partial[i+1] = partial[i] & chainIn[i];
        end
    endgenerate
    assign allHigh = partial[N];
endmodule
`default_nettype wire

// ===== tb/board_tester.sv
// board model: strap resistors on the address lines and an in-circuit tester
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module board_tester (
    input  wire logic [8:0]  strapAddressLinesOut,
    input  wire logic        strapAddressLinesOe,
    output logic      [8:0]  strapAddressLinesIn,
    output logic             resetPinN,
    output logic             crystalInput,
    output logic             memoryDataZero,
    output logic             memoryDataOne,
    output logic      [31:0] chainPins
);
    logic [8:0] pullDown;
    // released lines sit at the pull-up unless a resistor pulls them low
    assign strapAddressLinesIn = strapAddressLinesOe ? strapAddressLinesOut : ~pullDown;
    initial
    begin
        pullDown = 9'h000;
        resetPinN = 1'b0;
        crystalInput = 1'b0;
        memoryDataZero = 1'b1;
        memoryDataOne = 1'b1;
        chainPins = 32'hFFFFFFFF;
    end
    task automatic setStraps(input logic [8:0] m);
        pullDown <= m;
    endtask
    // every pin group except the straps is driven on each call, so a tester walks the chain by passing a new chain mask each time
    task automatic setPins(input logic rn, input logic d0, input logic d1, input logic x, input logic [31:0] ch);
        resetPinN <= rn;
        memoryDataZero <= d0;
        memoryDataOne <= d1;
        crystalInput <= x;
        chainPins <= ch;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// bench: strap capture, register port, tri-state and in-circuit test
// assumes the board model drives the reset, crystal, data, strap and chain pins; the bench drives the other inputs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk, rst, awvalid, wvalid, bready, arvalid, rready, verticalSyncIn;
    logic address24, address25, address26, address27, pixelClock, memoryClock;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [8:0]  memoryAddress, strapAddressLinesIn, strapAddressLinesOut;
    logic [31:0] chainPins;
    logic [2:0]  hostBusConfig;
    logic awready, wready, bvalid, arready, rvalid, strapAddressLinesOe, verticalSyncOut, verticalSyncOe;
    logic pinOutputEnable, address24Out, address25Out, activityIndicatorPin, backlightEnablePin;
    logic cpuClockDouble, externalOscSelect, upperAddressSelect, testModeEnable, clockTestMode, lowVoltageSelect;
    logic resetPinN, crystalInput, memoryDataZero, memoryDataOne, strapPullupEnable;
    int   error_cnt, checked;

    reset_strap_and_board_test u_dut (
        .sys_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .resetPinN, .crystalInput,
        .memoryDataZero, .memoryDataOne, .strapAddressLinesIn, .strapAddressLinesOut, .strapAddressLinesOe,
        .strapPullupEnable, .memoryAddress, .chainPins, .verticalSyncIn, .verticalSyncOut, .verticalSyncOe,
        .pinOutputEnable, .address24, .address25, .address26, .address27, .pixelClock, .memoryClock,
        .address24Out, .address25Out, .activityIndicatorPin, .backlightEnablePin, .hostBusConfig,
        .cpuClockDouble, .externalOscSelect, .upperAddressSelect, .testModeEnable, .clockTestMode,
        .lowVoltageSelect
    );
    board_tester u_board (
        .strapAddressLinesOut, .strapAddressLinesOe, .strapAddressLinesIn, .resetPinN, .crystalInput,
        .memoryDataZero, .memoryDataOne, .chainPins
    );

    always #12.5 sys_clk = ~sys_clk;

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] er);
        bit ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge sys_clk);
            ad = ad || awready;
            wd = wd || wready;
            if (ad)
                awvalid <= 1'b0;
            if (wd)
                wvalid <= 1'b0;
        end
        // bready stays high between calls, so no time step assigns it twice
        while (bvalid !== 1'b1)
            @(posedge sys_clk);
        check(bresp, er);
    endtask
    task automatic axiRead(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        // rready stays high between calls, so no time step assigns it twice
        while (rvalid !== 1'b1)
            @(posedge sys_clk);
        v = rdata;
        check(rresp, er);
    endtask
    // straps float onto the pull-ups while the reset pin is low
    task automatic pinReset(input logic [8:0] m);
        u_board.setStraps(m);
        u_board.setPins(1'b0, 1'b1, 1'b1, 1'b0, 32'hFFFFFFFF);
        tick(8);
        u_board.setPins(1'b1, 1'b1, 1'b1, 1'b0, 32'hFFFFFFFF);
        tick(8);
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end

    initial
    begin
        {sys_clk, awvalid, wvalid, bready, arvalid, rready, verticalSyncIn} = '0;
        {address24, address25, address26, address27, pixelClock, memoryClock} = '0;
        {awaddr, araddr, wdata, wstrb, memoryAddress} = '0;
        error_cnt = 0;
        checked = 0;
        rst = 1'b1;
        tick(20);
        rst <= 1'b0;
        pinReset(9'h1E4);
        check(hostBusConfig, 3'b011);
        check(cpuClockDouble, 1'b1);
        check(externalOscSelect, 1'b1);
        check(upperAddressSelect, 1'b1);
        check(testModeEnable, 1'b1);
        check(clockTestMode, 1'b1);
        check(lowVoltageSelect, 1'b1);
        check(strapPullupEnable, 1'b0);
        axiRead(reset_strap_pkg::STATUS_OFF, d, reset_strap_pkg::RESP_OKAY);
        check(d[8:0], 9'h01B);
        axiRead(reset_strap_pkg::EXT1_OFF, d, reset_strap_pkg::RESP_OKAY);
        check(d[3], 1'b1);
        memoryAddress <= 9'h0AA;
        u_board.setStraps(9'h1FF);
        tick(8);
        axiRead(reset_strap_pkg::STATUS_OFF, d, reset_strap_pkg::RESP_OKAY);
        check(d[8:0], 9'h01B);
        for (int i = 0; i < 2; i++)
        begin
            {pixelClock, address26} <= {2{i[0]}};
            {memoryClock, address27} <= {2{!i[0]}};
            tick(8);
            check({address24Out, address25Out}, {i[0], !i[0]});
            check({activityIndicatorPin, backlightEnablePin}, {i[0], !i[0]});
        end
        $display("test strap capture done");
        pinReset(9'h00B);
        check(hostBusConfig, 3'b100);
        check(cpuClockDouble, 1'b0);
        axiRead(reset_strap_pkg::EXT1_OFF, d, reset_strap_pkg::RESP_OKAY);
        check(d[3], 1'b0);
        for (int v = 0; v < 4; v++)
        begin
            axiWrite(reset_strap_pkg::CTRL_OFF, v, 4'h1, reset_strap_pkg::RESP_OKAY);
            tick(3);
            check({activityIndicatorPin, backlightEnablePin}, {v[0], v[1]});
        end
        axiWrite(reset_strap_pkg::CTRL_OFF, 32'h0, 4'h0, reset_strap_pkg::RESP_OKAY);
        axiWrite(reset_strap_pkg::STATUS_OFF, 32'h0, 4'hF, reset_strap_pkg::RESP_OKAY);
        tick(3);
        check({activityIndicatorPin, backlightEnablePin}, 2'h3);
        axiRead(12'h00C, d, reset_strap_pkg::RESP_SLVERR);
        check(d, 32'h0);
        $display("test register port done");
        u_board.setPins(1'b0, 1'b0, 1'b1, 1'b1, 32'hFFFFFFFF);
        tick(8);
        check({pinOutputEnable, verticalSyncOe}, 2'h0);
        axiRead(reset_strap_pkg::STATUS_OFF, d, reset_strap_pkg::RESP_OKAY);
        check(d[17:16], 2'h1);
        u_board.setPins(1'b0, 1'b1, 1'b1, 1'b0, 32'hFFFFFFFF);
        tick(8);
        check({pinOutputEnable, verticalSyncOe}, 2'h3);
        u_board.setPins(1'b0, 1'b0, 1'b1, 1'b1, 32'hFFFFFFFF);
        tick(8);
        u_board.setPins(1'b1, 1'b0, 1'b1, 1'b0, 32'hFFFFFFFF);
        tick(8);
        check({pinOutputEnable, verticalSyncOe, strapPullupEnable}, 3'h0);
        u_board.setPins(1'b0, 1'b0, 1'b1, 1'b0, 32'hFFFFFFFF);
        tick(8);
        check({pinOutputEnable, verticalSyncOe, strapPullupEnable}, 3'h7);
        $display("test tri-state done");
        for (int e = 0; e < 2; e++)
        begin
            u_board.setPins(1'b0, 1'b1, 1'b0, 1'b1, 32'hFFFFFFFF);
            verticalSyncIn <= 1'b0;
            tick(8);
            check({pinOutputEnable, verticalSyncOe}, 2'h1);
            check(verticalSyncOut, 1'b1);
            for (int k = 0; k < 32 && e == 0; k++)
            begin
                u_board.setPins(1'b0, 1'b1, 1'b0, 1'b1, ~(32'h1 << k));
                tick(6);
                check(verticalSyncOut, 1'b0);
                u_board.setPins(1'b0, 1'b1, 1'b0, 1'b1, 32'hFFFFFFFF);
                tick(6);
                check(verticalSyncOut, 1'b1);
            end
            // crystal goes last: its rising edge is what can end the test
            u_board.setPins(1'b0, 1'b1, 1'b0, 1'b0, 32'hFFFFFFFF);
            tick(6);
            check(verticalSyncOut, 1'b0);
            u_board.setPins(e[0], 1'b1, !e[0], 1'b1, 32'hFFFFFFFF);
            tick(8);
            check(pinOutputEnable, 1'b1);
            u_board.setPins(e[0], 1'b1, !e[0], 1'b0, 32'hFFFFFFFF);
            tick(4);
        end
        $display("test in-circuit chain done");
        finish_test();
    end
endmodule
`default_nettype wire
